// *** inc/vst_pkg.sv ***
// constants for the viterbi select and traceback datapath
package vst_pkg;
    localparam int WORD_W = 32;
    localparam int HALF_W = 16;
    localparam int STATE_W = 6;
    localparam int REGIDX_W = 4;
    localparam int MEMOP_W = 8;
    localparam logic [15:0] OPC_SEL_HIGH_PL = 16'hE3FF;
    localparam logic [15:0] OPC_SEL_LOW_PL = 16'hE3FE;
    localparam logic [15:0] OPC_SEL_LOW = 16'hE6F6;
    localparam logic [15:0] OPC_SEL_HIGH = 16'hE6F7;
    localparam logic [15:0] OPC_CLEAR = 16'hE529;
    localparam logic [15:0] OPC_TRACE_MEM = 16'hE20C;
    localparam logic [15:0] OPC_TRACE_REG = 16'hE528;
    localparam logic [7:0] MSW_ZERO_BYTE = 8'h00;
    localparam logic [3:0] REG_FIVE = 4'h5;
    localparam logic [3:0] REG_SIX = 4'h6;
    localparam logic [3:0] REG_SEVEN = 4'h7;
    localparam logic [3:0] REG_EIGHT = 4'h8;
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;
    localparam logic [5:0] STATE_SPLIT = 6'h20;
    typedef enum logic [2:0] {
        OP_NONE,
        OP_SELECT,
        OP_CLEAR,
        OP_TRACE_MEM,
        OP_TRACE_REG
    } vst_op_t;
endpackage : vst_pkg

// *** verilog/vst_decode.sv ***
// instruction word decoder for the select and traceback unit
`timescale 1ns/1ps
`default_nettype none
module vst_decode
    import vst_pkg::*;
(
    input wire logic [15:0] lsw,
    input wire logic [15:0] msw,
    output vst_pkg::vst_op_t op,
    output logic highHalf,
    output logic parLoad,
    output logic [3:0] metricZeroDest,
    output logic [3:0] metricOneDest
);
    always_comb
    begin
        op = OP_NONE;
        highHalf = 1'b0;
        parLoad = 1'b0;
        metricZeroDest = msw[15:12];
        metricOneDest = msw[11:8];
        case (lsw)
            OPC_SEL_HIGH_PL:
            begin
                op = OP_SELECT; // see RQ8
                highHalf = 1'b1;
                parLoad = 1'b1;
            end
            OPC_SEL_LOW_PL:
            begin
                op = OP_SELECT; // see RQ9
                parLoad = 1'b1;
            end
            OPC_SEL_LOW, OPC_SEL_HIGH:
            begin
                metricZeroDest = msw[7:4]; // see RQ10
                metricOneDest = msw[3:0];
                highHalf = (lsw == OPC_SEL_HIGH);
                if (msw[15:8] == MSW_ZERO_BYTE)
                begin
                    op = OP_SELECT;
                end
            end
            OPC_CLEAR: op = OP_CLEAR; // see RQ11
            OPC_TRACE_MEM:
            begin
                if (msw[15:8] == MSW_ZERO_BYTE)
                begin
                    op = OP_TRACE_MEM; // see RQ17
                end
            end
            OPC_TRACE_REG: op = OP_TRACE_REG; // see RQ22
            default: op = OP_NONE;
        endcase
    end
endmodule : vst_decode
`default_nettype wire

// *** verilog/vst_unit.sv ***
// viterbi select and traceback datapath extension
// Function
// RQ1: each select shifts both decision registers left, then inserts decision at bit 0
// RQ2: pair A: low strictly greater picks low, records 0; else high, records 1
// RQ3: pair B same compare; winner is metric 1, decision into register one
// RQ4: high variants write metrics into upper halves, lower halves kept
// RQ5: low variants write metrics into lower halves, same compare and recording
// RQ6: encoder limits metric-1 destination to six/eight, metric-0 to five/seven
// RQ7: parallel-load variants load a 32-bit memory word into parallel load target
// RQ8: decode high select with parallel load from its first-word pattern
// RQ9: decode low select with parallel load from its first-word pattern
// RQ10: decode plain low select; second word top byte zero, then two nibbles
// RQ11: clear instruction zeroes both decision registers
// RQ12: traceback takes state from bits 5:0, zeroes bits 31:6
// RQ13: state below 32 reads register zero at 31-S, else register one at 63-S
// RQ14: state 0 at bit 31 of register zero down to state 63 in one
// RQ15: memory traceback writes decoded bit at bit 0, bits 31:1 cleared
// RQ16: after traceback the state becomes twice previous plus decoded bit
// RQ17: decode memory traceback; second word top byte zero, operand low byte
// RQ18: software zeroes state register before the first traceback
// RQ19: every select, clear and traceback completes in one cycle
// RQ20: no instruction alters any vector status flag
// RQ21: parallel-load compare uses pre-instruction metrics; load does not disturb results
// RQ22: register traceback writes same bit into result register bit 0
`timescale 1ns/1ps
`default_nettype none
module vst_unit
    import vst_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic issue,
    input wire logic [15:0] instrLsw,
    input wire logic [15:0] instrMsw,
    input wire logic [vst_pkg::WORD_W-1:0] memReadData,
    input wire logic wrStateReg,
    input wire logic [vst_pkg::WORD_W-1:0] wrStateData,
    input wire logic wrDecisionRegs,
    input wire logic [vst_pkg::WORD_W-1:0] wrDecisionZero,
    input wire logic [vst_pkg::WORD_W-1:0] wrDecisionOne,
    input wire logic wrPathPairs,
    input wire logic [vst_pkg::WORD_W-1:0] wrPathPairA,
    input wire logic [vst_pkg::WORD_W-1:0] wrPathPairB,
    input wire logic wrDestRegs,
    input wire logic [vst_pkg::WORD_W-1:0] wrRegFive,
    input wire logic [vst_pkg::WORD_W-1:0] wrRegSix,
    input wire logic [vst_pkg::WORD_W-1:0] wrRegSeven,
    input wire logic [vst_pkg::WORD_W-1:0] wrRegEight,
    output logic [vst_pkg::WORD_W-1:0] decisionRegZero,
    output logic [vst_pkg::WORD_W-1:0] decisionRegOne,
    output logic [vst_pkg::WORD_W-1:0] tracebackStateReg,
    output logic [vst_pkg::WORD_W-1:0] tracebackResultReg,
    output logic [vst_pkg::WORD_W-1:0] parallelLoadTarget,
    output logic [vst_pkg::WORD_W-1:0] pathPairA,
    output logic [vst_pkg::WORD_W-1:0] pathPairB,
    output logic [vst_pkg::WORD_W-1:0] vectorRegFive,
    output logic [vst_pkg::WORD_W-1:0] vectorRegSix,
    output logic [vst_pkg::WORD_W-1:0] vectorRegSeven,
    output logic [vst_pkg::WORD_W-1:0] vectorRegEight,
    output logic memWrite,
    output logic [vst_pkg::MEMOP_W-1:0] memWriteOperand,
    output logic [vst_pkg::WORD_W-1:0] memWriteData,
    output logic done
);
    import vst_pkg::*;

    // ----------------------------------------
    // decode
    // ----------------------------------------
    vst_op_t op;
    logic highHalf;
    logic parLoad;
    logic [3:0] metricZeroDest;
    logic [3:0] metricOneDest;
    logic doSelect;
    logic doClear;
    logic doTrace;

    vst_decode u_decode (
        .lsw(instrLsw),
        .msw(instrMsw),
        .op(op),
        .highHalf(highHalf),
        .parLoad(parLoad),
        .metricZeroDest(metricZeroDest),
        .metricOneDest(metricOneDest)
    );

    assign doSelect = issue && (op == OP_SELECT);
    assign doClear = issue && (op == OP_CLEAR);
    assign doTrace = issue && ((op == OP_TRACE_MEM) || (op == OP_TRACE_REG));

    // ----------------------------------------
    // add-compare-select
    // ----------------------------------------
    // compare reads the registered pairs, so a parallel load cannot leak in
    function automatic logic pick_high(input logic [WORD_W-1:0] pair);
        pick_high = !(pair[HALF_W-1:0] > pair[WORD_W-1:HALF_W]); // see RQ2
    endfunction : pick_high

    function automatic logic [HALF_W-1:0] winner(input logic [WORD_W-1:0] pair);
        winner = pick_high(pair) ? pair[WORD_W-1:HALF_W] : pair[HALF_W-1:0];
    endfunction : winner

    function automatic logic [WORD_W-1:0] merge_half(
        input logic [WORD_W-1:0] old,
        input logic [HALF_W-1:0] val,
        input logic hi
    );
        merge_half = hi ? {val, old[HALF_W-1:0]} : {old[WORD_W-1:HALF_W], val};
    endfunction : merge_half

    logic decZero;
    logic decOne;
    logic [HALF_W-1:0] metricZero;
    logic [HALF_W-1:0] metricOne;

    assign decZero = pick_high(pathPairA); // see RQ21
    assign decOne = pick_high(pathPairB); // see RQ3
    assign metricZero = winner(pathPairA);
    assign metricOne = winner(pathPairB);

    // ----------------------------------------
    // traceback
    // ----------------------------------------
    logic [STATE_W-1:0] curState;
    logic traceBit;
    logic [STATE_W-1:0] next_state;

    assign curState = tracebackStateReg[STATE_W-1:0]; // see RQ12
    // bit order puts state 0 at the msb, hence the reversed index
    always_comb
    begin
        if (curState < STATE_SPLIT)
        begin
            traceBit = decisionRegZero[5'd31 - curState[4:0]]; // see RQ13 RQ14
        end
        else
        begin
            traceBit = decisionRegOne[5'd31 - curState[4:0]]; // see RQ13 RQ14
        end
    end
    assign next_state = {curState[STATE_W-2:0], traceBit}; // see RQ16

    // ----------------------------------------
    // decision registers
    // ----------------------------------------
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            decisionRegZero <= WORD_RESET;
            decisionRegOne <= WORD_RESET;
        end
        else if (doClear)
        begin
            decisionRegZero <= WORD_RESET; // see RQ11
            decisionRegOne <= WORD_RESET;
        end
        else if (doSelect)
        begin
            decisionRegZero <= {decisionRegZero[WORD_W-2:0], decZero}; // see RQ1 RQ2
            decisionRegOne <= {decisionRegOne[WORD_W-2:0], decOne}; // see RQ1 RQ3
        end
        else if (wrDecisionRegs)
        begin
            decisionRegZero <= wrDecisionZero;
            decisionRegOne <= wrDecisionOne;
        end
    end

    // ----------------------------------------
    // state metric destinations
    // ----------------------------------------
    // out-of-range destination fields simply write nothing
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            vectorRegFive <= WORD_RESET;
            vectorRegSix <= WORD_RESET;
            vectorRegSeven <= WORD_RESET;
            vectorRegEight <= WORD_RESET;
        end
        else if (doSelect)
        begin
            if (metricZeroDest == REG_FIVE)
            begin
                vectorRegFive <= merge_half(vectorRegFive, metricZero, highHalf); // see RQ4 RQ5
            end
            if (metricZeroDest == REG_SEVEN)
            begin
                vectorRegSeven <= merge_half(vectorRegSeven, metricZero, highHalf); // see RQ4 RQ5
            end
            if (metricOneDest == REG_SIX)
            begin
                vectorRegSix <= merge_half(vectorRegSix, metricOne, highHalf); // see RQ3 RQ6
            end
            if (metricOneDest == REG_EIGHT)
            begin
                vectorRegEight <= merge_half(vectorRegEight, metricOne, highHalf); // see RQ3 RQ6
            end
        end
        else if (wrDestRegs)
        begin
            vectorRegFive <= wrRegFive;
            vectorRegSix <= wrRegSix;
            vectorRegSeven <= wrRegSeven;
            vectorRegEight <= wrRegEight;
        end
    end

    // ----------------------------------------
    // path pairs and parallel load
    // ----------------------------------------
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pathPairA <= WORD_RESET;
            pathPairB <= WORD_RESET;
        end
        else if (wrPathPairs && !doSelect)
        begin
            pathPairA <= wrPathPairA;
            pathPairB <= wrPathPairB;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            parallelLoadTarget <= WORD_RESET;
        end
        else if (doSelect && parLoad)
        begin
            parallelLoadTarget <= memReadData; // see RQ7 RQ21
        end
    end

    // ----------------------------------------
    // traceback state and results
    // ----------------------------------------
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            tracebackStateReg <= WORD_RESET;
        end
        else if (doTrace)
        begin
            tracebackStateReg <= {{(WORD_W-STATE_W){1'b0}}, next_state}; // see RQ12 RQ16
        end
        else if (wrStateReg)
        begin
            tracebackStateReg <= wrStateData;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            tracebackResultReg <= WORD_RESET;
        end
        else if (issue && (op == OP_TRACE_REG))
        begin
            tracebackResultReg <= {{(WORD_W-1){1'b0}}, traceBit}; // see RQ22
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            memWrite <= 1'b0;
            memWriteOperand <= '0;
            memWriteData <= WORD_RESET;
        end
        else
        begin
            memWrite <= issue && (op == OP_TRACE_MEM);
            if (issue && (op == OP_TRACE_MEM))
            begin
                memWriteOperand <= instrMsw[MEMOP_W-1:0]; // see RQ17
                memWriteData <= {{(WORD_W-1){1'b0}}, traceBit}; // see RQ15
            end
        end
    end

    // one-cycle completion; no status flags exist here to disturb
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            done <= 1'b0;
        end
        else
        begin
            done <= doSelect || doClear || doTrace; // see RQ19 RQ20
        end
    end
endmodule : vst_unit
`default_nettype wire

// *** dv/vst_unit_chk.sv ***
// assertion checker for the select and traceback unit
`timescale 1ns/1ps
`default_nettype none
module vst_unit_chk
    import vst_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic issue,
    input wire logic [15:0] instrLsw,
    input wire logic [15:0] instrMsw,
    input wire logic [vst_pkg::WORD_W-1:0] memReadData,
    input wire logic [vst_pkg::WORD_W-1:0] pathPairA,
    input wire logic [vst_pkg::WORD_W-1:0] pathPairB,
    input wire logic [vst_pkg::WORD_W-1:0] decisionRegZero,
    input wire logic [vst_pkg::WORD_W-1:0] decisionRegOne,
    input wire logic [vst_pkg::WORD_W-1:0] tracebackStateReg,
    input wire logic [vst_pkg::WORD_W-1:0] tracebackResultReg,
    input wire logic [vst_pkg::WORD_W-1:0] parallelLoadTarget,
    input wire logic [vst_pkg::WORD_W-1:0] vectorRegFive,
    input wire logic memWrite,
    input wire logic [vst_pkg::MEMOP_W-1:0] memWriteOperand,
    input wire logic [vst_pkg::WORD_W-1:0] memWriteData,
    input wire logic done
);
    logic plv, sel, clr, trm, trr, bitExp;
    // ----------------------------------------
    // decode of the issued word
    // ----------------------------------------
    always_comb
    begin
        plv = instrLsw == OPC_SEL_HIGH_PL || instrLsw == OPC_SEL_LOW_PL;
        sel = plv || ((instrLsw == OPC_SEL_LOW || instrLsw == OPC_SEL_HIGH)
            && instrMsw[15:8] == MSW_ZERO_BYTE);
        clr = instrLsw == OPC_CLEAR;
        trm = instrLsw == OPC_TRACE_MEM && instrMsw[15:8] == MSW_ZERO_BYTE;
        trr = instrLsw == OPC_TRACE_REG;
        // low five bits inverted give 31-S and 63-S alike
        bitExp = tracebackStateReg[5] ? decisionRegOne[~tracebackStateReg[4:0]]
            : decisionRegZero[~tracebackStateReg[4:0]];
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_sel; issue && sel; endsequence
    sequence s_trace; issue && (trm || trr); endsequence
    sequence s_any; issue && (sel || clr || trm || trr); endsequence
    property p_clear; issue && clr |=> decisionRegZero == WORD_RESET && decisionRegOne == WORD_RESET; endproperty
    a_clear: assert property (p_clear) else $error("clear missed");
    property p_shift; s_sel |=> decisionRegZero[31:1] == $past(decisionRegZero[30:0])
        && decisionRegOne[31:1] == $past(decisionRegOne[30:0]); endproperty
    a_shift: assert property (p_shift) else $error("no shift");
    property p_bitA; s_sel |=> decisionRegZero[0] == !($past(pathPairA[15:0]) > $past(pathPairA[31:16])); endproperty
    a_bitA: assert property (p_bitA) else $error("bad bit A");
    property p_bitB; s_sel |=> decisionRegOne[0] == !($past(pathPairB[15:0]) > $past(pathPairB[31:16])); endproperty
    a_bitB: assert property (p_bitB) else $error("bad bit B");
    property p_load; issue && plv |=> parallelLoadTarget == $past(memReadData); endproperty
    a_load: assert property (p_load) else $error("bad load");
    property p_high; issue && instrLsw == OPC_SEL_HIGH_PL && instrMsw[15:12] == REG_FIVE |=>
        vectorRegFive == {($past(pathPairA[15:0]) > $past(pathPairA[31:16]) ? $past(pathPairA[15:0])
        : $past(pathPairA[31:16])), $past(vectorRegFive[15:0])}; endproperty
    a_high: assert property (p_high) else $error("bad high write");
    property p_trmem; issue && trm |=> memWrite && memWriteOperand == $past(instrMsw[7:0])
        && memWriteData == {31'h0, $past(bitExp)}; endproperty
    a_trmem: assert property (p_trmem) else $error("bad trace store");
    property p_trreg; issue && trr |=> tracebackResultReg == {31'h0, $past(bitExp)}; endproperty
    a_trreg: assert property (p_trreg) else $error("bad trace result");
    property p_state; s_trace |=> tracebackStateReg == {26'h0, $past(tracebackStateReg[4:0]), $past(bitExp)}; endproperty
    a_state: assert property (p_state) else $error("bad state");
    property p_done; s_any |=> done ##1 !done || $past(issue); endproperty
    a_done: assert property (p_done) else $error("done missing");
    property p_idle; !(issue && (sel || clr || trm || trr)) |=> !done && !memWrite; endproperty
    a_idle: assert property (p_idle) else $error("spurious done");
endmodule : vst_unit_chk
bind vst_unit vst_unit_chk i_chk (.clk, .rstn, .issue, .instrLsw, .instrMsw, .memReadData,
    .pathPairA, .pathPairB, .decisionRegZero, .decisionRegOne, .tracebackStateReg,
    .tracebackResultReg, .parallelLoadTarget, .vectorRegFive, .memWrite, .memWriteOperand,
    .memWriteData, .done);
`default_nettype wire

// *** dv/vst_mem_model.sv ***
// host data memory model facing the select and traceback unit
`timescale 1ns/1ps
`default_nettype none
module vst_mem_model
    import vst_pkg::*;
(
    input wire logic clk,
    input wire logic issue,
    input wire logic [vst_pkg::MEMOP_W-1:0] addr,
    input wire logic memWrite,
    input wire logic [vst_pkg::MEMOP_W-1:0] memWriteOperand,
    input wire logic [vst_pkg::WORD_W-1:0] memWriteData,
    output logic [vst_pkg::WORD_W-1:0] memReadData
);
    logic [WORD_W-1:0] mem [256];
    logic [WORD_W-1:0] noise = 32'h5A5A_C3C3;
    initial
    begin
        for (int i = 0; i < 256; i++)
            mem[i] = {4{8'(i)}} ^ 32'hC3C3_3C3C;
    end
    // read data only valid while issued, so a late sample sees noise
    assign memReadData = issue ? mem[addr] : noise;
    always @(posedge clk)
    begin
        noise <= {noise[30:0], noise[31] ^ noise[21]};
        if (memWrite)
            mem[memWriteOperand] <= memWriteData;
    end
endmodule : vst_mem_model
`default_nettype wire

// *** dv/viterbi_select_traceback_unit_bench.sv ***
// self-checking bench for the select and traceback unit
`timescale 1ns/1ps
`default_nettype none
module viterbi_select_traceback_unit_bench;
    import vst_pkg::*;
    logic clk = 1'b0, rstn = 1'b0, issue = 1'b0, wrAll = 1'b0, exMw = 1'b0;
    logic [15:0] instrLsw = 16'h0, instrMsw = 16'h0;
    logic [31:0] wrStateData = 32'h0, wrDecisionZero = 32'h0, wrDecisionOne = 32'h0;
    logic [31:0] wrPathPairA = 32'h0, wrPathPairB = 32'h0, wrRegFive = 32'h0;
    logic [31:0] wrRegSix = 32'h0, wrRegSeven = 32'h0, wrRegEight = 32'h0, memReadData;
    logic [31:0] decisionRegZero, decisionRegOne, tracebackStateReg, tracebackResultReg;
    logic [31:0] parallelLoadTarget, pathPairA, pathPairB, vectorRegFive, vectorRegSix;
    logic [31:0] vectorRegSeven, vectorRegEight, memWriteData, exMd;
    logic [7:0] memWriteOperand;
    logic memWrite, done;
    logic [31:0] d0 = 32'h0, d1 = 32'h0, st = 32'h0, pa = 32'h0, pb = 32'h0;
    logic [31:0] pl = 32'h0, rr = 32'h0;
    logic [31:0] rg [4] = '{32'h0, 32'h0, 32'h0, 32'h0};
    logic [15:0] ops [4] = '{OPC_SEL_HIGH_PL, OPC_SEL_LOW_PL, OPC_SEL_LOW, OPC_SEL_HIGH};
    logic [3:0] m0, m1;
    int k, miscompares = 0, checkCount = 0;
    always #12.5 clk = ~clk;
    vst_unit i_dut (.clk, .rstn, .issue, .instrLsw, .instrMsw, .memReadData,
        .wrStateReg(wrAll), .wrStateData, .wrDecisionRegs(wrAll), .wrDecisionZero,
        .wrDecisionOne, .wrPathPairs(wrAll), .wrPathPairA, .wrPathPairB, .wrDestRegs(wrAll),
        .wrRegFive, .wrRegSix, .wrRegSeven, .wrRegEight, .decisionRegZero, .decisionRegOne,
        .tracebackStateReg, .tracebackResultReg, .parallelLoadTarget, .pathPairA, .pathPairB,
        .vectorRegFive, .vectorRegSix, .vectorRegSeven, .vectorRegEight, .memWrite,
        .memWriteOperand, .memWriteData, .done);
    vst_mem_model i_mem (.clk, .issue, .addr(instrMsw[7:0]), .memWrite, .memWriteOperand,
        .memWriteData, .memReadData);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic give_verdict();
        $display("checks=%0d miscompares=%0d", checkCount, miscompares);
        if (miscompares == 0 && checkCount > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict
    task automatic cmpAll();
        chk(decisionRegZero, d0);
        chk(decisionRegOne, d1);
        chk(tracebackStateReg, st);
        chk(tracebackResultReg, rr);
        chk(parallelLoadTarget, pl);
        chk(pathPairA, pa);
        chk(pathPairB, pb);
        chk(vectorRegFive, rg[0]);
        chk(vectorRegSix, rg[1]);
        chk(vectorRegSeven, rg[2]);
        chk(vectorRegEight, rg[3]);
    endtask : cmpAll
    task automatic loadAll(input logic [31:0] s, input logic [31:0] a, input logic [31:0] b);
        @(posedge clk);
        {st, d0, d1, pa, pb} = {s, $urandom, $urandom, a, b};
        for (int i = 0; i < 4; i++)
            rg[i] = $urandom;
        wrAll <= 1'b1;
        {wrStateData, wrDecisionZero, wrDecisionOne, wrPathPairA, wrPathPairB} <= {st, d0, d1, a, b};
        {wrRegFive, wrRegSix, wrRegSeven, wrRegEight} <= {rg[0], rg[1], rg[2], rg[3]};
        @(posedge clk);
        wrAll <= 1'b0;
    endtask : loadAll
    // reference behaviour of one accepted instruction
    task automatic model(input logic [15:0] l, input logic [15:0] m);
        logic plv, ba, bb, tb;
        int z, o;
        plv = l[15:8] == 8'hE3;
        ba = !(pa[15:0] > pa[31:16]);
        bb = !(pb[15:0] > pb[31:16]);
        z = (plv ? m[15:12] : m[7:4]) - 5;
        o = (plv ? m[11:8] : m[3:0]) - 5;
        tb = st[5:0] < 32 ? d0[31 - st[5:0]] : d1[63 - st[5:0]];
        if (l == OPC_CLEAR)
            {d0, d1} = 64'h0;
        else if (l == OPC_TRACE_MEM || l == OPC_TRACE_REG)
        begin
            exMw = l == OPC_TRACE_MEM;
            exMd = {31'h0, tb};
            rr = exMw ? rr : exMd;
            st = {26'h0, st[4:0], tb};
        end
        else
        begin
            {d0, d1} = {d0[30:0], ba, d1[30:0], bb};
            if (l == OPC_SEL_HIGH_PL || l == OPC_SEL_HIGH)
                {rg[z][31:16], rg[o][31:16]} = {ba ? pa[31:16] : pa[15:0], bb ? pb[31:16] : pb[15:0]};
            else
                {rg[z][15:0], rg[o][15:0]} = {ba ? pa[31:16] : pa[15:0], bb ? pb[31:16] : pb[15:0]};
            pl = plv ? {4{m[7:0]}} ^ 32'hC3C3_3C3C : pl;
        end
    endtask : model
    task automatic exec(input logic [15:0] l, input logic [15:0] m, input logic good);
        @(posedge clk);
        {issue, instrLsw, instrMsw} <= {1'b1, l, m};
        exMw = 1'b0;
        if (good)
            model(l, m);
        @(posedge clk);
        issue <= 1'b0;
        #1;
        chk(done, good);
        chk(memWrite, exMw);
        if (exMw)
        begin
            chk(memWriteOperand, m[7:0]);
            chk(memWriteData, exMd);
        end
        cmpAll();
    endtask : exec
    initial
    begin
        void'($urandom(32'h215507E4));
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        #1;
        cmpAll();
        for (int n = 0; n < 96; n++)
        begin
            // first block pits equal halves and an unsigned boundary
            if (n % 8 == 0)
                loadAll($urandom, n < 8 ? 32'hFFFF_FFFF : $urandom, n < 8 ? 32'h0000_FFFF : $urandom);
            k = $urandom_range(6);
            m0 = $urandom_range(1) ? REG_SEVEN : REG_FIVE;
            m1 = $urandom_range(1) ? REG_EIGHT : REG_SIX;
            if (k < 4)
                // first two entries are the parallel-load forms with the wide second word
                exec(ops[k], k < 2 ? {m0, m1, 8'($urandom_range(255, 128))} : {8'h00, m0, m1}, 1'b1);
            else if (k == 4)
                exec(OPC_CLEAR, 16'($urandom), 1'b1);
            else
                exec(k == 5 ? OPC_TRACE_MEM : OPC_TRACE_REG, {8'h00, 8'($urandom_range(127))}, 1'b1);
        end
        exec(OPC_SEL_LOW, 16'h0156, 1'b0);
        exec(OPC_TRACE_MEM, 16'h0110, 1'b0);
        exec(16'h1234, 16'h0000, 1'b0);
        loadAll(32'h0, $urandom, $urandom);
        for (int n = 0; n < 12; n++)
            exec(n[0] ? OPC_TRACE_REG : OPC_TRACE_MEM, {8'h00, 8'(n)}, 1'b1);
        give_verdict();
    end
    initial
    begin
        repeat (5000) @(posedge clk);
        miscompares++;
        give_verdict();
    end
endmodule : viterbi_select_traceback_unit_bench
`default_nettype wire
